// *** include/pcr_pkg.sv ***
// Field layout, encodings and decode helpers for the capability registers
// How it works
// [R1] Cache/MMU register ignores all software writes
// [R2] Capacity equals ways times line times sets
// [R3] Line code zero means cache absent
// [R4] Bit 31 flags next register implemented
// [R5] TLB field holds entry count minus one
// [R6] L1 sets code: 64 shifted by code
// [R7] L1 line code: 0 none, 4..128 bytes
// [R8] L1 ways code: code plus one ways
// [R9] Coprocessor two bit: supported and attached
// [R10] Media bit: supported and element attached
// [R11] Perf counter bit reflects implementation
// [R12] Watch register bit reflects implementation
// [R13] Compression bit reflects implementation
// [R14] Debug port bit reflects implementation
// [R15] Float bit: supported and unit attached
// [R16] L3 custom bits writable, else zero
// [R17] L3 sets code: 64 doubled per step
// [R18] L3 line code: 0 none, 4..256 bytes
// [R19] Reserved geometry codes never presented; stable
package pcr_pkg;
  localparam logic [2:0] PCR_SEL_MMU = 3'h1;
  localparam logic [2:0] PCR_SEL_UPPER = 3'h2;
  localparam int PCR_MORE_BIT = 31;
  localparam int PCR_TLB_LSB = 25;
  localparam int PCR_TLB_W = 6;
  localparam int PCR_IS_LSB = 22;
  localparam int PCR_IL_LSB = 19;
  localparam int PCR_IA_LSB = 16;
  localparam int PCR_DS_LSB = 13;
  localparam int PCR_DL_LSB = 10;
  localparam int PCR_DA_LSB = 7;
  localparam int PCR_L1_W = 3;
  localparam int PCR_C2_BIT = 6;
  localparam int PCR_MD_BIT = 5;
  localparam int PCR_PC_BIT = 4;
  localparam int PCR_WR_BIT = 3;
  localparam int PCR_CA_BIT = 2;
  localparam int PCR_EP_BIT = 1;
  localparam int PCR_FP_BIT = 0;
  localparam int PCR_TU_LSB = 28;
  localparam int PCR_TU_W = 3;
  localparam int PCR_TS_LSB = 24;
  localparam int PCR_TL_LSB = 20;
  localparam int PCR_L3_W = 4;
  localparam logic [2:0] PCR_L1_SETS_MAX = 3'h6;
  localparam logic [2:0] PCR_L1_LINE_MAX = 3'h6;
  localparam logic [3:0] PCR_L3_SETS_MAX = 4'h7;
  localparam logic [3:0] PCR_L3_LINE_MAX = 4'h7;
  localparam logic [31:0] PCR_SETS_BASE = 32'h00000040;
  localparam logic [31:0] PCR_LINE_BASE = 32'h00000002;
  localparam logic [31:0] PCR_ZERO_WORD = 32'h00000000;
  localparam logic [2:0] PCR_TU_RESET = 3'h0;

  function automatic logic [31:0] pcr_sets(input logic [3:0] code);
    pcr_sets = PCR_SETS_BASE << code;
  endfunction : pcr_sets

  function automatic logic [31:0] pcr_line(input logic [3:0] code);
    pcr_line = (code == 4'h0) ? PCR_ZERO_WORD : (PCR_LINE_BASE << code);
  endfunction : pcr_line

  function automatic logic [31:0] pcr_ways(input logic [3:0] code);
    pcr_ways = {28'h0000000, code} + 32'h00000001;
  endfunction : pcr_ways
endpackage : pcr_pkg

// *** logic/pcr_sync.sv ***
// Three-stage synchroniser with agreement filter for attach pins
`timescale 1ns/10ps
`default_nettype none
module pcr_sync #(
  parameter int W = 3
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  logic [W-1:0] meta;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] level;
  logic [W-1:0] next_level;

  always_comb begin
    next_level = level;
    for (int i = 0; i < W; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
    end else begin
      meta <= i_async;
      stage2 <= meta;
      stage3 <= stage2;
      level <= next_level;
    end
  end

  assign o_level = level;
endmodule : pcr_sync
`default_nettype wire

// *** logic/pcr_geom.sv ***
// Cache capacity decode from sets, line and ways codes
`timescale 1ns/10ps
`default_nettype none
module pcr_geom
  import pcr_pkg::*;
(
  input wire logic [3:0] i_sets_code,
  input wire logic [3:0] i_line_code,
  input wire logic [3:0] i_ways_code,
  output logic [31:0] o_bytes,
  output logic o_present
);
  logic [31:0] sets_n;
  logic [31:0] line_n;
  logic [31:0] ways_n;

  always_comb begin
    sets_n = pcr_sets(i_sets_code); // R6 R17
    line_n = pcr_line(i_line_code); // R7 R18
    ways_n = pcr_ways(i_ways_code); // R8
    o_bytes = ways_n * line_n * sets_n; // R2
    o_present = (i_line_code != 4'h0); // R3
  end
endmodule : pcr_geom
`default_nettype wire

// *** logic/pcr_regs.sv ***
// Capability register bank with coprocessor-style read/write port
`timescale 1ns/10ps
`default_nettype none
module pcr_regs
  import pcr_pkg::*;
#(
  parameter logic [5:0] TLB_ENTRIES_M1 = 6'h3F,
  parameter logic [2:0] IC_SETS = 3'h2,
  parameter logic [2:0] IC_LINE = 3'h4,
  parameter logic [2:0] IC_WAYS = 3'h3,
  parameter logic [2:0] DC_SETS = 3'h2,
  parameter logic [2:0] DC_LINE = 3'h4,
  parameter logic [2:0] DC_WAYS = 3'h3,
  parameter logic [3:0] L3_SETS = 4'h0,
  parameter logic [3:0] L3_LINE = 4'h0,
  parameter logic L3_CUSTOM_IMPL = 1'b0,
  parameter logic HAS_UPPER = 1'b1,
  parameter logic HAS_THIRD = 1'b0,
  parameter logic COP2_SUPPORT = 1'b0,
  parameter logic MEDIA_SUPPORT = 1'b0,
  parameter logic PERF_IMPL = 1'b1,
  parameter logic WATCH_IMPL = 1'b1,
  parameter logic COMPRESS_IMPL = 1'b0,
  parameter logic DEBUG_IMPL = 1'b1,
  parameter logic FPU_SUPPORT = 1'b1
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic [2:0] I_SEL,
  input wire logic I_RD_EN,
  input wire logic I_WR_EN,
  input wire logic [31:0] I_WR_DATA,
  input wire logic I_COP2_ATTACHED,
  input wire logic I_MEDIA_ATTACHED,
  input wire logic I_FPU_ATTACHED,
  output logic [31:0] O_RD_DATA,
  output logic O_RD_VALID,
  output logic [31:0] O_ICACHE_BYTES,
  output logic [31:0] O_DCACHE_BYTES,
  output logic [31:0] O_L3_BYTES,
  output logic [2:0] O_L3_CUSTOM
);
  // Reserved codes fall back to a legal value
  function automatic logic [2:0] clamp_l1(input logic [2:0] code, input logic [2:0] max);
    clamp_l1 = (code > max) ? max : code;
  endfunction : clamp_l1

  function automatic logic [3:0] clamp_l3(input logic [3:0] code, input logic [3:0] max);
    clamp_l3 = (code > max) ? max : code;
  endfunction : clamp_l3

  logic [2:0] attached;
  logic cop2_att;
  logic media_att;
  logic fpu_att;

  logic [31:0] mmu_cap;
  logic [31:0] next_mmu_cap;
  logic [31:0] upper_cap;
  logic [31:0] next_upper_cap;
  logic [2:0] l3_custom;
  logic [2:0] next_l3_custom;

  logic [31:0] rd_data;
  logic [31:0] next_rd_data;
  logic rd_valid;
  logic next_rd_valid;

  logic [31:0] ic_bytes;
  logic [31:0] dc_bytes;
  logic [31:0] l3_bytes;
  logic [31:0] ic_bytes_q;
  logic [31:0] dc_bytes_q;
  logic [31:0] l3_bytes_q;
  logic ic_present;
  logic dc_present;
  logic l3_present;

  logic [2:0] is_code;
  logic [2:0] il_code;
  logic [2:0] ds_code;
  logic [2:0] dl_code;
  logic [3:0] ts_code;
  logic [3:0] tl_code;

  pcr_sync #(
    .W(3)
  ) u_attach_sync (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_async({I_COP2_ATTACHED, I_MEDIA_ATTACHED, I_FPU_ATTACHED}),
    .o_level(attached)
  );

  assign cop2_att = attached[2];
  assign media_att = attached[1];
  assign fpu_att = attached[0];

  // Geometry codes, reserved values never reach the register
  always_comb begin
    is_code = clamp_l1(IC_SETS, PCR_L1_SETS_MAX); // R19
    il_code = clamp_l1(IC_LINE, PCR_L1_LINE_MAX); // R19
    ds_code = clamp_l1(DC_SETS, PCR_L1_SETS_MAX); // R19
    dl_code = clamp_l1(DC_LINE, PCR_L1_LINE_MAX); // R19
    ts_code = clamp_l3(L3_SETS, PCR_L3_SETS_MAX); // R19
    tl_code = clamp_l3(L3_LINE, PCR_L3_LINE_MAX); // R19
  end

  pcr_geom u_icache (
    .i_sets_code({1'b0, mmu_cap[PCR_IS_LSB +: PCR_L1_W]}),
    .i_line_code({1'b0, mmu_cap[PCR_IL_LSB +: PCR_L1_W]}),
    .i_ways_code({1'b0, mmu_cap[PCR_IA_LSB +: PCR_L1_W]}),
    .o_bytes(ic_bytes),
    .o_present(ic_present)
  );

  pcr_geom u_dcache (
    .i_sets_code({1'b0, mmu_cap[PCR_DS_LSB +: PCR_L1_W]}),
    .i_line_code({1'b0, mmu_cap[PCR_DL_LSB +: PCR_L1_W]}),
    .i_ways_code({1'b0, mmu_cap[PCR_DA_LSB +: PCR_L1_W]}),
    .o_bytes(dc_bytes),
    .o_present(dc_present)
  );

  // Tertiary associativity lives outside this block: direct mapped assumed
  pcr_geom u_l3cache (
    .i_sets_code(upper_cap[PCR_TS_LSB +: PCR_L3_W]),
    .i_line_code(upper_cap[PCR_TL_LSB +: PCR_L3_W]),
    .i_ways_code(4'h0),
    .o_bytes(l3_bytes),
    .o_present(l3_present)
  );

  // Register contents
  always_comb begin
    next_mmu_cap = PCR_ZERO_WORD;
    next_mmu_cap[PCR_MORE_BIT] = HAS_UPPER; // R4
    next_mmu_cap[PCR_TLB_LSB +: PCR_TLB_W] = TLB_ENTRIES_M1; // R5
    next_mmu_cap[PCR_IS_LSB +: PCR_L1_W] = is_code; // R6
    next_mmu_cap[PCR_IL_LSB +: PCR_L1_W] = il_code; // R7
    next_mmu_cap[PCR_IA_LSB +: PCR_L1_W] = IC_WAYS; // R8
    next_mmu_cap[PCR_DS_LSB +: PCR_L1_W] = ds_code; // R6
    next_mmu_cap[PCR_DL_LSB +: PCR_L1_W] = dl_code; // R7
    next_mmu_cap[PCR_DA_LSB +: PCR_L1_W] = DC_WAYS; // R8
    next_mmu_cap[PCR_C2_BIT] = COP2_SUPPORT & cop2_att; // R9
    next_mmu_cap[PCR_MD_BIT] = MEDIA_SUPPORT & media_att; // R10
    next_mmu_cap[PCR_PC_BIT] = PERF_IMPL; // R11
    next_mmu_cap[PCR_WR_BIT] = WATCH_IMPL; // R12
    next_mmu_cap[PCR_CA_BIT] = COMPRESS_IMPL; // R13
    next_mmu_cap[PCR_EP_BIT] = DEBUG_IMPL; // R14
    next_mmu_cap[PCR_FP_BIT] = FPU_SUPPORT & fpu_att; // R15
    next_l3_custom = l3_custom;
    if (I_WR_EN && I_SEL == PCR_SEL_UPPER) begin
      next_l3_custom = I_WR_DATA[PCR_TU_LSB +: PCR_TU_W]; // R16
    end
    if (!L3_CUSTOM_IMPL) begin
      next_l3_custom = PCR_TU_RESET; // R16
    end
    next_upper_cap = PCR_ZERO_WORD;
    next_upper_cap[PCR_MORE_BIT] = HAS_THIRD; // R4
    next_upper_cap[PCR_TU_LSB +: PCR_TU_W] = next_l3_custom;
    next_upper_cap[PCR_TS_LSB +: PCR_L3_W] = ts_code; // R17
    next_upper_cap[PCR_TL_LSB +: PCR_L3_W] = tl_code; // R18
  end

  // Read port: writes to the cache/MMU word are simply dropped
  always_comb begin
    next_rd_valid = I_RD_EN;
    next_rd_data = PCR_ZERO_WORD;
    if (I_RD_EN) begin
      unique case (I_SEL)
        PCR_SEL_MMU: next_rd_data = mmu_cap; // R1
        PCR_SEL_UPPER: next_rd_data = upper_cap;
        default: next_rd_data = PCR_ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      mmu_cap <= PCR_ZERO_WORD;
      upper_cap <= PCR_ZERO_WORD;
      l3_custom <= PCR_TU_RESET;
      rd_data <= PCR_ZERO_WORD;
      rd_valid <= 1'b0;
      ic_bytes_q <= PCR_ZERO_WORD;
      dc_bytes_q <= PCR_ZERO_WORD;
      l3_bytes_q <= PCR_ZERO_WORD;
    end else begin
      mmu_cap <= next_mmu_cap;
      upper_cap <= next_upper_cap;
      l3_custom <= next_l3_custom;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      ic_bytes_q <= ic_present ? ic_bytes : PCR_ZERO_WORD; // R3
      dc_bytes_q <= dc_present ? dc_bytes : PCR_ZERO_WORD; // R3
      l3_bytes_q <= l3_present ? l3_bytes : PCR_ZERO_WORD; // R3
    end
  end

  assign O_RD_DATA = rd_data;
  assign O_RD_VALID = rd_valid;
  assign O_ICACHE_BYTES = ic_bytes_q;
  assign O_DCACHE_BYTES = dc_bytes_q;
  assign O_L3_BYTES = l3_bytes_q;
  assign O_L3_CUSTOM = l3_custom;

  logic settled;
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      settled <= 1'b0;
    end else begin
      settled <= 1'b1;
    end
  end

  property p_ro_mmu;
    @(posedge I_CLK) disable iff (I_RESET)
    settled && I_WR_EN && I_SEL == PCR_SEL_MMU |=> $stable(mmu_cap[31:7]);
  endproperty
  a_ro_mmu: assert property (p_ro_mmu) else $error("write changed cache/MMU word"); // R1

  property p_capacity;
    @(posedge I_CLK) disable iff (I_RESET)
    settled ##1 1'b1 |-> O_ICACHE_BYTES == pcr_ways({1'b0, $past(mmu_cap[18:16])})
      * pcr_line({1'b0, $past(mmu_cap[21:19])}) * pcr_sets({1'b0, $past(mmu_cap[24:22])});
  endproperty
  a_capacity: assert property (p_capacity) else $error("icache capacity mismatch"); // R2

  property p_absent;
    @(posedge I_CLK) disable iff (I_RESET)
    settled && mmu_cap[PCR_DL_LSB +: PCR_L1_W] == 3'h0 |=> O_DCACHE_BYTES == 32'h00000000;
  endproperty
  a_absent: assert property (p_absent) else $error("absent dcache shows capacity"); // R3

  property p_chain;
    @(posedge I_CLK) disable iff (I_RESET)
    settled |-> mmu_cap[PCR_MORE_BIT] == HAS_UPPER && upper_cap[PCR_MORE_BIT] == HAS_THIRD;
  endproperty
  a_chain: assert property (p_chain) else $error("chain bit wrong"); // R4

  property p_no_reserved;
    @(posedge I_CLK) disable iff (I_RESET)
    settled |-> mmu_cap[24:22] != 3'h7 && mmu_cap[21:19] != 3'h7
      && mmu_cap[15:13] != 3'h7 && mmu_cap[12:10] != 3'h7
      && upper_cap[27:24] <= 4'h7 && upper_cap[23:20] <= 4'h7;
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved geometry code"); // R19

  property p_attach;
    @(posedge I_CLK) disable iff (I_RESET)
    settled |-> (!mmu_cap[PCR_C2_BIT] || COP2_SUPPORT) && (!mmu_cap[PCR_MD_BIT] || MEDIA_SUPPORT)
      && (!mmu_cap[PCR_FP_BIT] || FPU_SUPPORT);
  endproperty
  a_attach: assert property (p_attach) else $error("unit bit set without support"); // R9

  property p_custom_wr;
    @(posedge I_CLK) disable iff (I_RESET)
    I_WR_EN && I_SEL == PCR_SEL_UPPER |=>
      upper_cap[30:28] == (L3_CUSTOM_IMPL ? $past(I_WR_DATA[30:28]) : 3'h0);
  endproperty
  a_custom_wr: assert property (p_custom_wr) else $error("tertiary custom field wrong"); // R16

  property p_read;
    @(posedge I_CLK) disable iff (I_RESET)
    I_RD_EN && I_SEL == PCR_SEL_MMU |=> O_RD_VALID && O_RD_DATA == $past(mmu_cap);
  endproperty
  a_read: assert property (p_read) else $error("read data mismatch"); // R1

  property p_tlb;
    @(posedge I_CLK) disable iff (I_RESET)
    settled |-> mmu_cap[30:25] == TLB_ENTRIES_M1;
  endproperty
  a_tlb: assert property (p_tlb) else $error("tlb field wrong"); // R5

  property p_read_upper;
    @(posedge I_CLK) disable iff (I_RESET)
    I_RD_EN && I_SEL == PCR_SEL_UPPER |=> O_RD_VALID && O_RD_DATA == $past(upper_cap);
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper read data mismatch"); // R16

  property p_idle;
    @(posedge I_CLK) disable iff (I_RESET)
    !I_RD_EN |=> !O_RD_VALID && O_RD_DATA == PCR_ZERO_WORD;
  endproperty
  a_idle: assert property (p_idle) else $error("read port active without request"); // R1

  property p_l3_capacity;
    @(posedge I_CLK) disable iff (I_RESET)
    settled |=> O_L3_BYTES == pcr_line($past(upper_cap[23:20])) * pcr_sets($past(upper_cap[27:24]));
  endproperty
  a_l3_capacity: assert property (p_l3_capacity) else $error("tertiary capacity mismatch"); // R2

  property p_custom_hold;
    @(posedge I_CLK) disable iff (I_RESET)
    settled && !(I_WR_EN && I_SEL == PCR_SEL_UPPER) |=> $stable(O_L3_CUSTOM);
  endproperty
  a_custom_hold: assert property (p_custom_hold) else $error("custom field moved without write"); // R16

  property p_stable;
    @(posedge I_CLK) disable iff (I_RESET)
    settled |=> $stable(mmu_cap[31:7]) && $stable(upper_cap[27:20]);
  endproperty
  a_stable: assert property (p_stable) else $error("preset fields moved"); // R19
endmodule : pcr_regs
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the capability register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pcr_pkg::*;
  localparam int MAX_CYCLES = 3000;
  logic I_CLK = 1'b0;
  logic I_RESET = 1'b1;
  logic [2:0] I_SEL = 3'h0;
  logic I_RD_EN = 1'b0;
  logic I_WR_EN = 1'b0;
  logic [31:0] I_WR_DATA = 32'h00000000;
  logic I_COP2_ATTACHED = 1'b0;
  logic I_MEDIA_ATTACHED = 1'b0;
  logic I_FPU_ATTACHED = 1'b0;
  logic [31:0] O_RD_DATA;
  logic O_RD_VALID;
  logic [31:0] O_ICACHE_BYTES;
  logic [31:0] O_DCACHE_BYTES;
  logic [31:0] O_L3_BYTES;
  logic [2:0] O_L3_CUSTOM;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] rd;

  // Absent data cache, reserved tertiary codes, writable custom field
  pcr_regs #(
    .DC_LINE(3'h0), .L3_SETS(4'hF), .L3_LINE(4'hF), .L3_CUSTOM_IMPL(1'b1), .COP2_SUPPORT(1'b1)
  ) u_pcr_regs (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .I_SEL(I_SEL), .I_RD_EN(I_RD_EN),
    .I_WR_EN(I_WR_EN), .I_WR_DATA(I_WR_DATA), .I_COP2_ATTACHED(I_COP2_ATTACHED),
    .I_MEDIA_ATTACHED(I_MEDIA_ATTACHED), .I_FPU_ATTACHED(I_FPU_ATTACHED),
    .O_RD_DATA(O_RD_DATA), .O_RD_VALID(O_RD_VALID), .O_ICACHE_BYTES(O_ICACHE_BYTES),
    .O_DCACHE_BYTES(O_DCACHE_BYTES), .O_L3_BYTES(O_L3_BYTES), .O_L3_CUSTOM(O_L3_CUSTOM)
  );

  always #2 I_CLK = ~I_CLK;

  always @(posedge I_CLK) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // Expected first word for the chosen build
  function automatic logic [31:0] mmu_word(input logic c2, input logic fp);
    mmu_word = {1'b1, 6'h3F, 3'h2, 3'h4, 3'h3, 3'h2, 3'h0, 3'h3, c2, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, fp};
  endfunction : mmu_word

  function automatic logic [31:0] upper_word(input logic [2:0] custom);
    upper_word = {1'b0, custom, 4'h7, 4'h7, 20'h00000};
  endfunction : upper_word

  task automatic reg_read(input logic [2:0] sel, output logic [31:0] data);
    int k;
    I_SEL = sel;
    I_RD_EN = 1'b1;
    @(posedge I_CLK);
    #1;
    I_RD_EN = 1'b0;
    data = 32'hDEADBEEF;
    for (k = 0; k < 4; k++) begin
      if (O_RD_VALID === 1'b1) begin
        data = O_RD_DATA;
        break;
      end
      @(posedge I_CLK);
      #1;
    end
    check({31'h0, O_RD_VALID}, 32'h00000001);
    @(posedge I_CLK);
    #1;
    check({31'h0, O_RD_VALID}, 32'h00000000);
  endtask : reg_read

  task automatic reg_write(input logic [2:0] sel, input logic [31:0] data);
    I_SEL = sel;
    I_WR_DATA = data;
    I_WR_EN = 1'b1;
    @(posedge I_CLK);
    #1;
    I_WR_EN = 1'b0;
    repeat (2) @(posedge I_CLK);
    #1;
  endtask : reg_write

  task automatic test_preset();
    reg_read(PCR_SEL_MMU, rd);
    check(rd, mmu_word(1'b0, 1'b0));
    reg_read(PCR_SEL_UPPER, rd);
    check(rd, upper_word(3'h0));
    check(O_ICACHE_BYTES, 32'h00008000);
    check(O_DCACHE_BYTES, 32'h00000000);
    check(O_L3_BYTES, 32'h00200000);
  endtask : test_preset

  task automatic test_writes();
    reg_write(PCR_SEL_MMU, 32'hFFFFFFFF);
    reg_read(PCR_SEL_MMU, rd);
    check(rd, mmu_word(1'b0, 1'b0));
    reg_write(PCR_SEL_UPPER, 32'hFFFFFFFF);
    check({29'h0, O_L3_CUSTOM}, 32'h00000007);
    reg_read(PCR_SEL_UPPER, rd);
    check(rd, upper_word(3'h7));
    reg_write(PCR_SEL_UPPER, 32'h50000000);
    reg_read(PCR_SEL_UPPER, rd);
    check(rd, upper_word(3'h5));
  endtask : test_writes

  task automatic test_attach();
    I_COP2_ATTACHED = 1'b1;
    I_MEDIA_ATTACHED = 1'b1;
    repeat (8) @(posedge I_CLK);
    #1;
    reg_read(PCR_SEL_MMU, rd);
    check(rd, mmu_word(1'b1, 1'b0));
    I_COP2_ATTACHED = 1'b0;
    I_FPU_ATTACHED = 1'b1;
    repeat (8) @(posedge I_CLK);
    #1;
    reg_read(PCR_SEL_MMU, rd);
    check(rd, mmu_word(1'b0, 1'b1));
  endtask : test_attach

  task automatic test_unmapped();
    int s;
    for (s = 0; s < 8; s++) begin
      if (s != 1 && s != 2) begin
        reg_read(s[2:0], rd);
        check(rd, 32'h00000000);
      end
    end
  endtask : test_unmapped

  initial begin
    repeat (10) @(posedge I_CLK);
    #1;
    I_RESET = 1'b0;
    repeat (3) @(posedge I_CLK);
    #1;
    test_preset();
    test_writes();
    test_unmapped();
    test_attach();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
